/* rtl/sysreg_pkg.sv */
// Constants, field layouts and register types for the board system register block
package sysreg_pkg;

  // I/O addresses
  localparam logic [7:0] ADDR_FLASH_CTRL = 8'h78;
  localparam logic [7:0] ADDR_WDOG = 8'h79;
  localparam logic [7:0] ADDR_SELFTEST = 8'h80;
  localparam logic [7:0] ADDR_INS_PWR_STAT = 8'hE1;
  localparam logic [7:0] ADDR_BOARD_REV = 8'hE2;
  localparam logic [7:0] ADDR_SWITCH_RB = 8'hE3;
  localparam logic [7:0] ADDR_NET_ROUTE = 8'hE4;
  localparam logic [7:0] ADDR_VIDEO_LAMP = 8'hE5;
  localparam logic [7:0] ADDR_HOST_FN_INDEX = 8'hE6;
  localparam logic [7:0] ADDR_HOST_FN_WINDOW = 8'hE7;
  localparam logic [7:0] ADDR_IRQ_STAT_MASK = 8'hE8;

  // Read answers for locations this block does not back
  localparam logic [7:0] RD_UNMAPPED = 8'hFF;
  localparam logic [7:0] RD_MAPPED_ONLY = 8'h00;

  // Flash page control layout, bit 7 down to bit 0
  typedef struct packed {
    logic boot_override;
    logic [2:0] page;
    logic rsvd3;
    logic scratch;
    logic wr_en;
    logic rsvd0;
  } flash_ctrl_t;

  // Two-stage timer control layout, bit 7 down to bit 0
  typedef struct packed {
    logic stage2_stat;
    logic stage1_stat;
    logic stage2_en;
    logic stage1_en;
    logic steer_init;
    logic [2:0] timeout_code;
  } wdog_ctrl_t;

  localparam flash_ctrl_t FLASH_CTRL_RST = 8'h00;
  localparam wdog_ctrl_t WDOG_CTRL_RST = 8'h00;
  localparam logic [7:0] SELFTEST_RST = 8'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned STAGE2_DELAY_MS_DEF = 250;
  localparam int unsigned TC_NOM_PCT = 130;
  localparam int unsigned TC_MIN_MS [8] = '{250, 500, 1000, 8000, 32000, 64000, 128000, 256000};
  localparam int unsigned MS_CNT_W = 19;

  typedef enum logic [1:0] {
    WD_IDLE,
    WD_COUNT,
    WD_PENDING
  } wd_state_t;

endpackage

/* rtl/board_system_regs_watchdog.sv */
// Board system registers: flash page control, two-stage watchdog, self-test LED port
//
// Summary of operation
// - Flash control register clears to zero on init or any reset.
// - Bit 7 set forces onboard flash boot; clear lets boot switch decide.
// - Flash control bits 6:4 drive flash address lines A24:A22.
// - Flash control bit 2 is a scratch bit with no board effect.
// - Stage-two status sets on reset timeout; a written zero clears it.
// - Power-up clears stage-two status; watchdog-caused hard reset keeps it.
// - Stage-one status sets when timeout asserts NMI or INIT; cleared by written zero.
// - Power-up or hard reset clears stage-one status and both enables.
// - With stage two disabled, timeout gives no reset and no status.
// - Stage two enabled: reset output about 250 ms after stage-one event.
// - Both enable bits read zero after a timeout and stay clear until written again.
// - With stage one disabled, timeout gives no NMI and no status.
// - Stage one enabled: NMI asserts once the coded interval elapses.
// - Bit 3 steers the stage-one output to NMI or INIT.
// - Bits 2:0 hold the written terminal count code and read it back.
// - Code sets minimum timeout, 250 ms through 256 s.
// - Timeout never below the minimum, nominally thirty percent longer.
// - Terminal count code is 000 after power-up and any hard reset.
// - Self-test port latches written byte onto eight LEDs.
`timescale 1ns/1ps

module board_system_regs_watchdog
  import sysreg_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = MS_TICK_CYCLES_DEF,
  parameter int unsigned STAGE2_DELAY_MS = STAGE2_DELAY_MS_DEF
) (
  // Clock and resets
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_hard_rst,
  input wire logic i_hard_rst_by_wdog,
  input wire logic i_init,
  // Host I/O space access
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // Board inputs
  input wire logic i_boot_source_switch,
  input wire logic i_enum_asserted,
  // Flash control
  output logic o_boot_from_onboard,
  output logic [2:0] o_flash_page,
  output logic o_flash_wr_en,
  // Watchdog outputs
  output logic o_nmi,
  output logic o_init,
  output logic o_board_rst,
  // Self-test LEDs
  output logic [7:0] o_selftest_led
);

  localparam int unsigned PRE_W = $clog2(MS_TICK_CYCLES + 1);

  // Elaboration checks
  if (MS_TICK_CYCLES < 1) begin : g_chk_tick
    $error("MS_TICK_CYCLES must be at least one");
  end
  if (STAGE2_DELAY_MS < 1 || STAGE2_DELAY_MS >= (1 << MS_CNT_W)) begin : g_chk_s2
    $error("STAGE2_DELAY_MS out of counter range");
  end
  if (PRE_W > 31) begin : g_chk_pre
    $error("MS_TICK_CYCLES too large for the prescaler");
  end

  // nominal limits
  // Table of nominal limits in ms, one entry per timeout code
  wire logic [MS_CNT_W-1:0] limit_tbl [8];
  for (genvar c = 0; c < 8; c++) begin : g_limit
    localparam int unsigned NOM_MS = TC_MIN_MS[c] * TC_NOM_PCT / 100;
    // Integer rounding must never bring a limit under its coded minimum
    if (NOM_MS < TC_MIN_MS[c] || NOM_MS >= (1 << MS_CNT_W)) begin : g_chk_nom
      $error("Nominal limit outside the ms counter range");
    end
    assign limit_tbl[c] = MS_CNT_W'(NOM_MS);
  end

  // Register state
  flash_ctrl_t flash_q;
  flash_ctrl_t flash_d;
  wdog_ctrl_t wdog_q;
  wdog_ctrl_t wdog_d;
  wdog_ctrl_t wdog_hard;

  // Timer state
  wd_state_t state_q;
  wd_state_t state_d;
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;
  logic [MS_CNT_W-1:0] ms_q;
  logic [MS_CNT_W-1:0] ms_d;

  // Access decode
  wire logic wr_flash = i_io_wr && (i_io_addr == ADDR_FLASH_CTRL);
  wire logic wr_wdog = i_io_wr && (i_io_addr == ADDR_WDOG);
  wire logic wr_selftest = i_io_wr && (i_io_addr == ADDR_SELFTEST);
  wire logic any_rst = !i_nrst || i_hard_rst;
  wire logic hit_mapped_only = (i_io_addr == ADDR_BOARD_REV) || (i_io_addr == ADDR_SWITCH_RB) ||
                               (i_io_addr == ADDR_NET_ROUTE) || (i_io_addr == ADDR_VIDEO_LAMP) ||
                               (i_io_addr == ADDR_HOST_FN_INDEX) || (i_io_addr == ADDR_HOST_FN_WINDOW) ||
                               (i_io_addr == ADDR_IRQ_STAT_MASK);
  wire logic rd_hit_flash = (i_io_addr == ADDR_FLASH_CTRL);
  wire logic rd_hit_wdog = (i_io_addr == ADDR_WDOG);
  wire logic rd_hit_ins_pwr = (i_io_addr == ADDR_INS_PWR_STAT);
  wire logic flash_clr = any_rst || i_init;

  // Write data fields of the timer control register
  wire logic [2:0] wr_code = i_io_wdata[2:0];
  wire logic wr_steer = i_io_wdata[3];
  wire logic wr_stage1_en = i_io_wdata[4];
  wire logic wr_stage2_en = i_io_wdata[5];
  wire logic wr_keep_stage1 = i_io_wdata[6];
  wire logic wr_keep_stage2 = i_io_wdata[7];
  wire logic wr_arm = wr_stage1_en || wr_stage2_en;
  // Status clears need a written zero; a written one leaves the bit alone
  wire logic clr_stage1 = wr_wdog && !wr_keep_stage1;
  wire logic clr_stage2 = wr_wdog && !wr_keep_stage2;

  // Timer events
  wire logic tick = (pre_q == PRE_W'(MS_TICK_CYCLES - 1));
  // Prescaler, restarted on arming and held at zero while idle, gives the one-ms tick
  wire logic [PRE_W-1:0] pre_next = tick ? '0 : pre_q + PRE_W'(1);
  wire logic [MS_CNT_W-1:0] ms_next = tick ? ms_q + MS_CNT_W'(1) : ms_q;
  wire logic any_en = wdog_q.stage1_en || wdog_q.stage2_en;
  wire logic in_count = (state_q == WD_COUNT);
  wire logic in_pending = (state_q == WD_PENDING);
  wire logic [MS_CNT_W-1:0] limit_ms = limit_tbl[wdog_q.timeout_code];
  wire logic limit_hit = (ms_q >= limit_ms);
  wire logic delay_hit = (ms_q >= MS_CNT_W'(STAGE2_DELAY_MS));
  // A write in the same cycle restarts the count instead of firing
  // interval elapsed
  wire logic timeout_ev = in_count && any_en && limit_hit && !wr_wdog;
  wire logic stage2_fire = in_pending && delay_hit && !wr_wdog;
  wire logic stage1_ev = timeout_ev && wdog_q.stage1_en;
  wire logic nmi_ev = stage1_ev && !wdog_q.steer_init;
  wire logic init_ev = stage1_ev && wdog_q.steer_init;

  // Flash control next value
  always_comb begin
    flash_d = flash_q;
    if (wr_flash) begin
      flash_d = flash_ctrl_t'(i_io_wdata);
      flash_d.rsvd3 = 1'b0;
      flash_d.rsvd0 = 1'b0;
    end
  end

  // Watchdog register next value
  always_comb begin
    wdog_d = wdog_q;
    if (wr_wdog) begin
      wdog_d.timeout_code = wr_code;
      wdog_d.steer_init = wr_steer;
      wdog_d.stage1_en = wr_stage1_en;
      wdog_d.stage2_en = wr_stage2_en;
    end
    if (clr_stage1) begin
      wdog_d.stage1_stat = 1'b0;
    end
    if (clr_stage2) begin
      wdog_d.stage2_stat = 1'b0;
    end
    if (timeout_ev) begin
      wdog_d.stage1_en = 1'b0;
      wdog_d.stage2_en = 1'b0;
    end
    if (stage1_ev) begin
      wdog_d.stage1_stat = 1'b1;
    end
    if (stage2_fire) begin
      wdog_d.stage2_stat = 1'b1;
    end
  end

  // Hard reset image of the watchdog register
  always_comb begin
    wdog_hard = WDOG_CTRL_RST;
    wdog_hard.stage2_stat = i_hard_rst_by_wdog && (wdog_q.stage2_stat || stage2_fire);
  end

  // Timer sequencing
  always_comb begin
    state_d = state_q;
    pre_d = pre_next;
    ms_d = ms_next;
    // Resolution is one ms: a timeout lands on the first tick at or past the limit
    unique case (state_q)
      WD_IDLE: begin
        // Counters parked at zero so arming starts a full interval
        pre_d = '0;
        ms_d = '0;
        if (any_en) begin
          state_d = WD_COUNT;
        end
      end
      WD_COUNT: begin
        if (!any_en) begin
          state_d = WD_IDLE;
        end else if (timeout_ev) begin
          pre_d = '0;
          ms_d = '0;
          state_d = wdog_q.stage2_en ? WD_PENDING : WD_IDLE;
        end
      end
      WD_PENDING: begin
        // Stage-one interval has elapsed; only a write or any reset cancels the board reset
        if (stage2_fire) begin
          state_d = WD_IDLE;
        end
      end
    endcase
    if (wr_wdog) begin
      pre_d = '0;
      ms_d = '0;
      state_d = wr_arm ? WD_COUNT : WD_IDLE;
    end
  end

  // Read data selection
  wire logic [7:0] ins_pwr_stat = {wdog_q.stage1_stat, i_enum_asserted, 6'h00};
  wire logic [7:0] rd_val = rd_hit_flash ? flash_q :
                            rd_hit_wdog ? wdog_q :
                            rd_hit_ins_pwr ? ins_pwr_stat :
                            hit_mapped_only ? RD_MAPPED_ONLY : RD_UNMAPPED;

  // cleared by init or any reset
  always_ff @(posedge i_sys_clk) begin
    if (flash_clr) begin
      flash_q <= FLASH_CTRL_RST;
    end else begin
      flash_q <= flash_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      wdog_q <= WDOG_CTRL_RST;
    end else if (i_hard_rst) begin
      wdog_q <= wdog_hard;
    end else begin
      wdog_q <= wdog_d;
    end
  end

  // Timer state, prescaler and ms count restart together on any reset
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      state_q <= WD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_d;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      ms_q <= '0;
    end else begin
      ms_q <= ms_d;
    end
  end

  // Stage outputs are single-cycle pulses; the board sequencer stretches reset
  // stage-one NMI
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      o_nmi <= 1'b0;
    end else begin
      o_nmi <= nmi_ev;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      o_init <= 1'b0;
    end else begin
      o_init <= init_ev;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      o_board_rst <= 1'b0;
    end else begin
      o_board_rst <= stage2_fire;
    end
  end

  // Flash pins follow the register one cycle later
  // Held low through power-up reset; the switch shows through other clears
  wire logic boot_in_rst = i_nrst && i_boot_source_switch;
  wire logic boot_sel = flash_q.boot_override || i_boot_source_switch;

  always_ff @(posedge i_sys_clk) begin
    if (flash_clr) begin
      o_boot_from_onboard <= boot_in_rst;
    end else begin
      o_boot_from_onboard <= boot_sel;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (flash_clr) begin
      o_flash_page <= 3'h0;
    end else begin
      o_flash_page <= flash_q.page;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (flash_clr) begin
      o_flash_wr_en <= 1'b0;
    end else begin
      o_flash_wr_en <= flash_q.wr_en;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      o_selftest_led <= SELFTEST_RST;
    end else if (wr_selftest) begin
      o_selftest_led <= i_io_wdata;
    end
  end

  // A read and a write in one cycle: the read returns the old value
  // Read data is held until the next read or a power-up reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_rd) begin
      o_io_rdata <= rd_val;
    end
  end

endmodule // board_system_regs_watchdog

/* sim/sysreg_chk_checker.sv */
// Port-level assertions for the board system register block
`timescale 1ns/1ps
module sysreg_chk
  import sysreg_pkg::*;
#(
  parameter int unsigned MS_TICK_CYCLES = 2,
  parameter int unsigned STAGE2_DELAY_MS = 4
) (
  // Clock and resets
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_hard_rst,
  input wire logic i_init,
  // Host access
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  // Block outputs
  input wire logic o_boot_from_onboard,
  input wire logic [2:0] o_flash_page,
  input wire logic o_flash_wr_en,
  input wire logic o_nmi,
  input wire logic o_init,
  input wire logic o_board_rst,
  input wire logic [7:0] o_selftest_led
);
  localparam int unsigned MIN1 = 250 * MS_TICK_CYCLES;
  localparam int unsigned MIN2 = MIN1 + STAGE2_DELAY_MS * MS_TICK_CYCLES;
  // Shortest code bounds every timeout, so one floor serves all codes
  logic [19:0] since_q;
  wire restart = i_hard_rst || (i_io_wr && i_io_addr == ADDR_WDOG);
  wire [2:0] wr_page = i_io_wdata[6:4];
  wire wr_we = i_io_wdata[1];
  always_ff @(posedge i_sys_clk) begin
    since_q <= (!i_nrst || restart) ? 20'h0 : since_q + 20'h1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_fwr;
    i_io_wr && i_io_addr == ADDR_FLASH_CTRL && !i_hard_rst && !i_init;
  endsequence
  sequence s_quiet2;
    (!i_io_wr && !i_hard_rst && !i_init) [*2];
  endsequence
  property p_rd_hold; !i_io_rd |=> $stable(o_io_rdata); endproperty
  property p_wo_read; i_io_rd && i_io_addr == ADDR_SELFTEST |=> o_io_rdata == RD_UNMAPPED; endproperty
  property p_steer; !(o_nmi && o_init); endproperty
  property p_pulse; (o_nmi || o_init || o_board_rst) |=> !(o_nmi || o_init || o_board_rst); endproperty
  property p_min1; (o_nmi || o_init) |-> since_q >= MIN1; endproperty
  property p_min2; o_board_rst |-> since_q >= MIN2; endproperty
  property p_ovr; s_fwr ##0 i_io_wdata[7] ##1 s_quiet2 |-> o_boot_from_onboard; endproperty
  property p_page;
    s_fwr ##1 s_quiet2 |-> o_flash_page == $past(wr_page, 2) && o_flash_wr_en == $past(wr_we, 2);
  endproperty
  property p_clr; (i_init || i_hard_rst) |-> ##[1:2] (o_flash_page == 3'h0 && !o_flash_wr_en); endproperty
  property p_led; i_io_wr && i_io_addr == ADDR_SELFTEST && !i_hard_rst |=> o_selftest_led == $past(i_io_wdata);
  endproperty
  property p_hrst; i_hard_rst |=> o_selftest_led == SELFTEST_RST && !o_nmi && !o_board_rst; endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  a_wo_read: assert property (p_wo_read) else $error("self-test port read back");
  a_steer: assert property (p_steer) else $error("NMI and INIT together");
  a_pulse: assert property (p_pulse) else $error("timeout output longer than one cycle");
  a_min1: assert property (p_min1) else $error("stage one came too early");
  a_min2: assert property (p_min2) else $error("board reset came too early");
  a_ovr: assert property (p_ovr) else $error("override did not force onboard boot");
  a_page: assert property (p_page) else $error("flash pins differ from written value");
  a_clr: assert property (p_clr) else $error("flash control not cleared");
  a_led: assert property (p_led) else $error("LEDs differ from written byte");
  a_hrst: assert property (p_hrst) else $error("hard reset left outputs set");
endmodule // sysreg_chk

bind board_system_regs_watchdog sysreg_chk #(.MS_TICK_CYCLES(MS_TICK_CYCLES),
  .STAGE2_DELAY_MS(STAGE2_DELAY_MS)) u_chk (.*);

/* sim/io_host_model.sv */
// Host processor model issuing I/O space reads and writes
`timescale 1ns/1ps
module io_host_model
  import sysreg_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // I/O space
  output logic [7:0] o_io_addr,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata
);
  initial begin
    o_io_addr = 8'h00;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_io_addr = a;
    o_io_wdata = (a == ADDR_FLASH_CTRL) ? (d & 8'hF6) : d;
    o_io_wr = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_io_wr = 1'b0;
    // Released data is scrambled so a stale value cannot pass
    o_io_wdata = ~o_io_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_io_addr = a;
    o_io_rd = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_io_rd = 1'b0;
    d = i_io_rdata;
  endtask
endmodule // io_host_model

/* sim/board_system_regs_watchdog_bench.sv */
// Self-checking bench for the board system register block
`timescale 1ns/1ps
module board_system_regs_watchdog_bench;
  import sysreg_pkg::*;
  logic clk, nrst, hrst, hby, ini, sw, enm, wr, rd, boot, we, nmi, ini_o, brst;
  logic [7:0] addr, wdat, rdat, led;
  logic [2:0] page;
  int err_count, total_checks, cyc, n;
  io_host_model host (.i_sys_clk(clk), .o_io_addr(addr), .o_io_wr(wr), .o_io_rd(rd), .o_io_wdata(wdat),
    .i_io_rdata(rdat));
  board_system_regs_watchdog #(.MS_TICK_CYCLES(2), .STAGE2_DELAY_MS(4)) dut (.i_sys_clk(clk), .i_nrst(nrst),
    .i_hard_rst(hrst), .i_hard_rst_by_wdog(hby), .i_init(ini), .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd),
    .i_io_wdata(wdat), .o_io_rdata(rdat), .i_boot_source_switch(sw), .i_enum_asserted(enm),
    .o_boot_from_onboard(boot), .o_flash_page(page), .o_flash_wr_en(we), .o_nmi(nmi), .o_init(ini_o),
    .o_board_rst(brst), .o_selftest_led(led));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    check(v, exp);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic hard(input logic by);
    hby = by;
    hrst = 1'b1;
    step(1);
    hrst = 1'b0;
    hby = 1'b0;
  endtask
  // Counts cycles until the chosen pulse; gives up after 2000
  task automatic wait_ev(input int s);
    logic hit;
    hit = 1'b0;
    n = 0;
    while (hit !== 1'b1 && n < 2000) begin
      step(1);
      n++;
      hit = (s == 0) ? nmi : (s == 1) ? ini_o : brst;
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic sc_def();
    enm = 1'b1;
    rchk(ADDR_FLASH_CTRL, 8'h00);
    rchk(ADDR_WDOG, 8'h00);
    rchk(ADDR_INS_PWR_STAT, 8'h40);
    rchk(ADDR_VIDEO_LAMP, 8'h00);
    rchk(8'h10, RD_UNMAPPED);
  endtask
  task automatic sc_flash();
    host.wr(ADDR_FLASH_CTRL, 8'hFF);
    rchk(ADDR_FLASH_CTRL, 8'hF6);
    check({page, we, boot, 3'h0}, 8'hF8);
    host.wr(ADDR_FLASH_CTRL, 8'h04);
    rchk(ADDR_FLASH_CTRL, 8'h04);
    check({page, we, boot, 3'h0}, 8'h00);
    sw = 1'b1;
    step(2);
    check({7'h0, boot}, 8'h01);
    host.wr(ADDR_FLASH_CTRL, 8'h72);
    ini = 1'b1;
    step(1);
    ini = 1'b0;
    sw = 1'b0;
    rchk(ADDR_FLASH_CTRL, 8'h00);
  endtask
  task automatic sc_wdog_rw();
    host.wr(ADDR_WDOG, 8'hCB);
    rchk(ADDR_WDOG, 8'h0B);
    for (int i = 0; i < 8; i++) begin
      host.wr(ADDR_WDOG, 8'(i));
      rchk(ADDR_WDOG, 8'(i));
    end
    hard(1'b0);
    rchk(ADDR_WDOG, 8'h00);
  endtask
  task automatic sc_stage1();
    host.wr(ADDR_WDOG, 8'h10);
    step(300);
    host.wr(ADDR_WDOG, 8'h10);
    wait_ev(0);
    check(8'(n >= 500 && n <= 660), 8'h01);
    wait_ev(2);
    check(8'(n == 2000), 8'h01);
    rchk(ADDR_WDOG, 8'h40);
    host.wr(ADDR_WDOG, 8'h40);
    rchk(ADDR_WDOG, 8'h40);
    host.wr(ADDR_WDOG, 8'h00);
    rchk(ADDR_WDOG, 8'h00);
  endtask
  task automatic sc_init_path();
    host.wr(ADDR_WDOG, 8'h39);
    wait_ev(1);
    check(8'(n >= 1000 && n <= 1310), 8'h01);
    wait_ev(2);
    check(8'(n >= 6 && n <= 10), 8'h01);
    rchk(ADDR_WDOG, 8'hC9);
    hard(1'b1);
    rchk(ADDR_WDOG, 8'h80);
    hard(1'b0);
    rchk(ADDR_WDOG, 8'h00);
  endtask
  task automatic sc_stage2();
    host.wr(ADDR_WDOG, 8'h20);
    wait_ev(2);
    check(8'(n >= 508 && n <= 670), 8'h01);
    rchk(ADDR_WDOG, 8'h80);
    host.wr(ADDR_SELFTEST, 8'hA5);
    check(led, 8'hA5);
    host.wr(ADDR_SELFTEST, 8'h5A);
    check(led, 8'h5A);
    rchk(ADDR_SELFTEST, RD_UNMAPPED);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    {nrst, hrst, hby, ini, sw, enm} = 6'h00;
    step(20);
    nrst = 1'b1;
    sc_def();
    sc_flash();
    sc_wdog_rw();
    sc_stage1();
    sc_init_path();
    sc_stage2();
    wrap_up();
  end
endmodule // board_system_regs_watchdog_bench
